// File: irq_pkg.sv
// Package for the interrupt flag and priority register block.
// Assumes an AXI4-Lite master with 32-bit data; registers are 16 bits.
package irq_pkg;
  localparam int ADDR_W = 4;
  localparam int REG_W  = 16;
  localparam int PRI_W  = 3;
  localparam int NSRC   = 17; // 15 flag sources + spare slots in map
  // Byte offsets (no offsets printed, chosen locally)
  localparam logic [ADDR_W-1:0] OFS_FLAGS3  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PRI3    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PRI27   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_REQUEST = 4'hc;
  // Implemented bit masks
  localparam logic [REG_W-1:0] FLAGS3_MASK = 16'hffef;
  localparam logic [REG_W-1:0] PRI3_MASK   = 16'h7777;
  localparam logic [REG_W-1:0] PRI27_MASK  = 16'h7770;
  // Reset values: flags clear, priorities level 4
  localparam logic [REG_W-1:0] FLAGS3_RST  = 16'h0000;
  localparam logic [REG_W-1:0] PRI3_RST    = 16'h4444;
  localparam logic [REG_W-1:0] PRI27_RST   = 16'h4440;
  localparam logic [PRI_W-1:0] PRI_OFF     = 3'h0;
  // Program restart address after reset
  localparam logic [23:0] RESET_PC = 24'h000000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: irq_pri_field.sv
// One source's priority/flag qualifier.
// Assumes flag and field come from registers on the same clock.
`timescale 1ns/100ps
module irq_pri_field
  import irq_pkg::*;
(
  input  wire logic [PRI_W-1:0] i_pri,
  input  wire logic             i_flag,
  output logic      [PRI_W-1:0] o_level
);
  // Code zero or a clear flag masks source; else level is the code
  assign o_level = (i_flag && i_pri != PRI_OFF) ? i_pri : PRI_OFF;
endmodule

// File: irq_arbiter.sv
// Picks the most urgent level; ties go to the lowest source index.
// Assumes levels are already gated by the priority code.
`timescale 1ns/100ps
module irq_arbiter
  import irq_pkg::*;
#(
  parameter int N = 16
)
(
  input  wire logic [N*PRI_W-1:0] i_levels,
  output logic      [PRI_W-1:0]   o_level,
  output logic      [4:0]         o_index
);
  // Strict greater-than keeps the lower index on a tie
  always_comb
  begin
    o_level = PRI_OFF;
    o_index = 5'h00;
    for (int k = 0; k < N; k++)
    begin
      if (i_levels[k*PRI_W +: PRI_W] > o_level)
      begin
        o_level = i_levels[k*PRI_W +: PRI_W];
        o_index = 5'(k);
      end
    end
  end
endmodule

// File: irq_flag_priority_regs.sv
// Interrupt flag and priority registers with request presentation.
// Assumes one clock, synchronous active-low reset, AXI4-Lite master.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module irq_flag_priority_regs
  import irq_pkg::*;
(
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_N,
  input  wire logic [REG_W-1:0]    I_SRC_EVENT,
  input  wire logic [ADDR_W-1:0]   I_AWADDR,
  input  wire logic                I_AWVALID,
  output logic                     O_AWREADY,
  input  wire logic [31:0]         I_WDATA,
  input  wire logic [3:0]          I_WSTRB,
  input  wire logic                I_WVALID,
  output logic                     O_WREADY,
  output logic [1:0]               O_BRESP,
  output logic                     O_BVALID,
  input  wire logic                I_BREADY,
  input  wire logic [ADDR_W-1:0]   I_ARADDR,
  input  wire logic                I_ARVALID,
  output logic                     O_ARREADY,
  output logic [31:0]              O_RDATA,
  output logic [1:0]               O_RRESP,
  output logic                     O_RVALID,
  input  wire logic                I_RREADY,
  output logic                     O_IRQ_REQ,
  output logic [PRI_W-1:0]         O_IRQ_LEVEL,
  output logic [4:0]               O_IRQ_INDEX,
  output logic [23:0]              O_RESTART_PC
);

  // Source-to-field map: flag bits 15..0 use fields of the two registers
  localparam int NF = 16;

  logic [REG_W-1:0] flags_reg, flags_next;
  logic [REG_W-1:0] pri3_reg, pri3_next;
  logic [REG_W-1:0] pri27_reg, pri27_next;
  logic [REG_W-1:0] ev_meta_reg, ev_sync_reg;
  logic             aw_hold_reg, aw_hold_next;
  logic             w_hold_reg, w_hold_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [REG_W-1:0] w_data_reg, w_data_next;
  logic [1:0]       w_strb_reg, w_strb_next;
  logic             bvalid_reg, bvalid_next;
  logic [1:0]       bresp_reg, bresp_next;
  logic             rvalid_reg, rvalid_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic [1:0]       rresp_reg, rresp_next;
  logic             req_reg, req_next;
  logic [PRI_W-1:0] lvl_reg, lvl_next;
  logic [4:0]       idx_reg, idx_next;
  logic [NF*PRI_W-1:0] levels;
  logic [PRI_W-1:0] win_level;
  logic [4:0]       win_index;
  logic             wr_fire;
  logic             aw_take, w_take, ar_take;
  logic             awready_next, wready_next, arready_next;

  // Merge byte lanes of a 16-bit register, keeping unimplemented bits zero
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old_v,
    input logic [REG_W-1:0] new_v,
    input logic [1:0]       strb,
    input logic [REG_W-1:0] mask
  );
    logic [REG_W-1:0] be;
    be = {{8{strb[1]}}, {8{strb[0]}}};
    return ((old_v & ~be) | (new_v & be)) & mask;
  endfunction

  // Field k mod 8 of the combined priority map
  function automatic logic [PRI_W-1:0] pri_of(input int k,
    input logic [REG_W-1:0] p3, input logic [REG_W-1:0] p27);
    logic [2*REG_W-1:0] both;
    both = {p27, p3};
    return both[(k % 8) * 4 +: PRI_W];
  endfunction

  // Event pins cross in through two flops
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      ev_meta_reg <= 16'h0000;
      ev_sync_reg <= 16'h0000;
    end
    else
    begin
      ev_meta_reg <= I_SRC_EVENT;
      ev_sync_reg <= ev_meta_reg;
    end
  end

  // Qualify each flag with its priority code
  genvar g;
  generate
    for (g = 0; g < NF; g++)
    begin : gen_src
      irq_pri_field u_field (
        .i_pri   (pri_of(g, pri3_reg, pri27_reg)),
        .i_flag  (flags_reg[g]),
        .o_level (levels[g*PRI_W +: PRI_W])
      );
    end
  endgenerate

  // Lower index is the lower vector position
  irq_arbiter #(.N(NF)) u_arb (
    .i_levels (levels),
    .o_level  (win_level),
    .o_index  (win_index)
  );

  // A channel counts as taken only while its ready is shown, which keeps
  // the first cycle after reset from accepting a request early
  assign aw_take = I_AWVALID && O_AWREADY;
  assign w_take  = I_WVALID && O_WREADY;
  assign ar_take = I_ARVALID && O_ARREADY;

  // Both halves held and no answer waiting
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

  // Write channel: address and data taken in either order
  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (aw_take)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = I_AWADDR;
    end
    if (w_take)
    begin
      w_hold_next = 1'b1;
      w_data_next = I_WDATA[REG_W-1:0];
      w_strb_next = I_WSTRB[1:0];
    end
    if (wr_fire)
    begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      case (aw_addr_reg)
        OFS_FLAGS3, OFS_PRI3, OFS_PRI27, OFS_REQUEST: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    else if (bvalid_reg && I_BREADY)
      bvalid_next = 1'b0;
  end

  // Register file; hardware set wins over a software clear
  always_comb
  begin
    flags_next = flags_reg;
    pri3_next  = pri3_reg;
    pri27_next = pri27_reg;
    if (wr_fire)
    begin
      case (aw_addr_reg)
        OFS_FLAGS3:
          flags_next = merge16(flags_reg, w_data_reg, w_strb_reg,
                               FLAGS3_MASK);
        OFS_PRI3:
          pri3_next = merge16(pri3_reg, w_data_reg, w_strb_reg, PRI3_MASK);
        OFS_PRI27:
          pri27_next = merge16(pri27_reg, w_data_reg, w_strb_reg,
                               PRI27_MASK);
        default: ;
      endcase
    end
    // Events OR in last, so a set beats a clear in the same cycle
    flags_next = flags_next | (ev_sync_reg & FLAGS3_MASK);
  end

  // Read channel, one cycle to answer
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && I_RREADY)
      rvalid_next = 1'b0;
    else if (ar_take)
    begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      // Status word: request at bit 11, index 10:6, level 2:0
      case (I_ARADDR)
        OFS_FLAGS3:  rdata_next = {16'h0000, flags_reg};
        OFS_PRI3:    rdata_next = {16'h0000, pri3_reg};
        OFS_PRI27:   rdata_next = {16'h0000, pri27_reg};
        OFS_REQUEST: rdata_next = {16'h0000, 4'h0, req_reg, idx_reg,
                                   3'h0, lvl_reg};
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  // Request toward the core; reset itself raises nothing
  // Registered a cycle after the arbiter so the core sees settled values
  always_comb
  begin
    req_next = (win_level != PRI_OFF);
    lvl_next = win_level;
    idx_next = win_index;
  end

  // State registers; reset restores documented values
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      flags_reg   <= FLAGS3_RST;
      pri3_reg    <= PRI3_RST;
      pri27_reg   <= PRI27_RST;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 16'h0000;
      w_strb_reg  <= 2'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
      req_reg     <= 1'b0;
      lvl_reg     <= PRI_OFF;
      idx_reg     <= 5'h00;
    end
    else
    begin
      flags_reg   <= flags_next;
      pri3_reg    <= pri3_next;
      pri27_reg   <= pri27_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      req_reg     <= req_next;
      lvl_reg     <= lvl_next;
      idx_reg     <= idx_next;
    end
  end

  // Readies drop while a channel is held or an answer waits, so a
  // second request cannot slip in before the response is taken
  always_comb
  begin
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next  = !w_hold_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  // Ready flags are registered holds, no combinational path
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      O_AWREADY    <= 1'b0;
      O_WREADY     <= 1'b0;
      O_ARREADY    <= 1'b0;
      O_RESTART_PC <= RESET_PC;
    end
    else
    begin
      O_AWREADY    <= awready_next;
      O_WREADY     <= wready_next;
      O_ARREADY    <= arready_next;
      O_RESTART_PC <= RESET_PC;
    end
  end

  assign O_BVALID    = bvalid_reg;
  assign O_BRESP     = bresp_reg;
  assign O_RVALID    = rvalid_reg;
  assign O_RDATA     = rdata_reg;
  assign O_RRESP     = rresp_reg;
  assign O_IRQ_REQ   = req_reg;
  assign O_IRQ_LEVEL = lvl_reg;
  assign O_IRQ_INDEX = idx_reg;

endmodule

// File: irq_flag_priority_regs_sva.sv
// Checker for the flag and priority register block, top ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module irq_regs_checker
  import irq_pkg::*;
(
  input wire logic             I_REF_CLK,
  input wire logic             I_RST_N,
  input wire logic             I_AWVALID,
  input wire logic             O_AWREADY,
  input wire logic             I_WVALID,
  input wire logic             O_WREADY,
  input wire logic [1:0]       O_BRESP,
  input wire logic             O_BVALID,
  input wire logic             I_BREADY,
  input wire logic             I_ARVALID,
  input wire logic             O_ARREADY,
  input wire logic [31:0]      O_RDATA,
  input wire logic             O_RVALID,
  input wire logic             I_RREADY,
  input wire logic             O_IRQ_REQ,
  input wire logic [PRI_W-1:0] O_IRQ_LEVEL,
  input wire logic [4:0]       O_IRQ_INDEX,
  input wire logic [23:0]      O_RESTART_PC
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  // Request, level and restart address
  a_restart_zero: assert property (O_RESTART_PC == 24'h000000)
    else $error("restart address not zero");
  a_reset_quiet: assert property ($rose(I_RST_N) |->
    !O_IRQ_REQ && !O_BVALID && !O_RVALID) else $error("busy after reset");
  a_req_level: assert property (O_IRQ_REQ == (O_IRQ_LEVEL != 3'h0))
    else $error("request and level disagree");
  a_index_valid: assert property (O_IRQ_REQ |->
    O_IRQ_INDEX < 5'h10 && O_IRQ_INDEX != 5'h04) else $error("bad index");
  // Bus answers stand until taken
  a_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:16] == 0)
    else $error("upper read bits set");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_rvalid_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  a_bvalid_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
    O_WREADY |-> ##[1:2] O_BVALID) else $error("write answer late");
  a_busy_ready: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("ready during pending answer");
  c_top_level: cover property (O_IRQ_REQ && O_IRQ_LEVEL == 3'h7);
  c_write_ok: cover property (O_BVALID && O_BRESP == RESP_OKAY);
  c_read_done: cover property (O_RVALID && I_RREADY);
endmodule

bind irq_flag_priority_regs irq_regs_checker u_chk (.I_REF_CLK, .I_RST_N,
  .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID,
  .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RVALID, .I_RREADY,
  .O_IRQ_REQ, .O_IRQ_LEVEL, .O_IRQ_INDEX, .O_RESTART_PC);

// File: irq_core_model.sv
// Core-side model: samples the prioritised request lines each cycle.
// Assumes the block's clock and synchronous active-low reset.
`timescale 1ns/100ps
module irq_core_model
  import irq_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_req,
  input  wire logic [PRI_W-1:0] i_level,
  input  wire logic [4:0]       i_index,
  output logic      [8:0]       o_taken
);
  // Core only sees requests; reset never reaches it as one
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_taken <= 9'h000;
    else
      o_taken <= {i_req, i_index, i_level};
  end
endmodule

// File: irq_flag_priority_regs_test.sv
// Testbench: AXI4-Lite master, source events and a core model.
// Assumes the package offsets, masks and reset values.
`timescale 1ns/100ps
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module irq_flag_priority_regs_test;
  import irq_pkg::*;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] src;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire logic   awready, wready, bvalid, arready, rvalid, req;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  lvl;
  wire logic [4:0]  idx;
  wire logic [23:0] pc;
  wire logic [8:0]  seen;
  int          fails, tests_run;

  irq_flag_priority_regs u_irq_flag_priority_regs (.I_REF_CLK(clk),
    .I_RST_N(rst_n), .I_SRC_EVENT(src), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ_REQ(req),
    .O_IRQ_LEVEL(lvl), .O_IRQ_INDEX(idx), .O_RESTART_PC(pc));
  irq_core_model u_irq_core_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_req(req), .i_level(lvl), .i_index(idx), .o_taken(seen));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Most urgent flagged source, lowest index on a tie
  function automatic logic [8:0] arb(logic [15:0] f, logic [31:0] p);
    logic [2:0] b, v;
    logic [4:0] ix;
    b = 3'h0;
    ix = 5'h00;
    for (int n = 0; n < 16; n++)
    begin
      v = p[4*(n%8) +: 3];
      if (f[n] && v > b)
      begin
        b = v;
        ix = 5'(n);
      end
    end
    return {b != 3'h0, ix, b};
  endfunction

  // Write one register, releasing each channel once taken
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    bready <= 1'b0;
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", RESP_OKAY, bresp)
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    rready <= 1'b0;
    d = rdata[15:0];
    r = rresp;
    `CHK("rvalid", 1'b1, rvalid)
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK("rdata", e, d)
    `CHK("rresp", RESP_OKAY, r)
  endtask

  // Program flags and fields, then compare request lines and status
  task automatic setup(input logic [15:0] f, input logic [31:0] p);
    logic [8:0] e;
    e = arb(f & FLAGS3_MASK, p & {PRI27_MASK, PRI3_MASK});
    wr(OFS_PRI3, p[15:0]);
    wr(OFS_PRI27, p[31:16]);
    wr(OFS_FLAGS3, f);
    rc(OFS_FLAGS3, f & FLAGS3_MASK);
    rc(OFS_PRI27, p[31:16] & PRI27_MASK);
    repeat (3) @(posedge clk);
    `CHK("req_lvl", {e[8], e[2:0]}, {req, lvl})
    if (e[8])
    begin
      `CHK("index", e[7:3], idx)
      `CHK("core", e, seen)
      rc(OFS_REQUEST, {4'h0, e[8:3], 3'h0, e[2:0]});
    end
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("pc", RESET_PC, pc)
    `CHK("req", 1'b0, req)
    rc(OFS_FLAGS3, FLAGS3_RST);
    rc(OFS_PRI3, PRI3_RST);
    rc(OFS_PRI27, PRI27_RST);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end

  initial
  begin
    logic [15:0] d;
    logic [1:0]  r;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {src, awaddr, araddr, wdata} = '0;
    wstrb = 4'h3;
    void'($urandom(32'haffd));
    do_reset;
    setup(16'hffff, 32'hffffffff);
    setup(16'h0006, 32'h55505555);
    setup(16'hffef, 32'h00000000);
    setup(16'h0100, 32'h00000001);
    for (int i = 0; i < 20; i++)
      setup(16'($urandom), $urandom);
    // Event pins set flags; unimplemented bit stays clear
    wr(OFS_FLAGS3, 16'h0000);
    src <= 16'h8011;
    repeat (2) @(posedge clk);
    src <= 16'h0000;
    repeat (6) @(posedge clk);
    rc(OFS_FLAGS3, 16'h8001);
    // Byte strobes: only the upper lane is written
    wr(OFS_PRI3, 16'h1234);
    wstrb <= 4'h2;
    wr(OFS_PRI3, 16'h0000);
    wstrb <= 4'h3;
    rc(OFS_PRI3, 16'h0034);
    rd(4'h2, d, r);
    `CHK("bad_resp", RESP_SLVERR, r)
    `CHK("bad_data", 16'h0000, d)
    do_reset;
    test_done;
  end
endmodule
